/* File: becr_defines.vh */
// becr_defines.vh: offsets, reset values and field positions of the bus fault capture registers
// assumes byte addressing on a 32-bit register bus, one aligned word per register
`ifndef BECR_DEFINES_VH
`define BECR_DEFINES_VH

`define BECR_ADDR_W           8
`define BECR_OFF_FAULT_ADDR   8'h04
`define BECR_OFF_FAULT_CTRL   8'h14
`define BECR_OFF_VECTOR_CTRL  8'h18
`define BECR_FAULT_ADDR_RST   32'h0000_0000
`define BECR_FAULT_CTRL_RST   1'h0
`define BECR_VECTOR_CTRL_RST  1'h1
`define BECR_BIT_SUPPRESS     0
`define BECR_BIT_DIRECT       0
`define BECR_RESP_OKAY        2'h0
`define BECR_RESP_SLVERR      2'h2
`define BECR_IRQ_N            8

`endif

/* File: becr_err_master.sv */
// becr_err_master.sv: processor master port raising bus errors
// assumes the system clock from the bench
`timescale 1ns/100ps
`default_nettype none
module becr_err_master (
	input  wire logic        clk_i,  // clock
	output var  logic        err_o,  // error pulse
	output var  logic [31:0] addr_o  // erroring address
);
	initial begin
		err_o = 1'b0;
		addr_o = 32'h0;
	end
	// address only valid with the pulse, so scramble it after
	task fire(input logic [31:0] a);
		@(posedge clk_i);
		err_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		err_o <= 1'b0;
		addr_o <= ~a;
	endtask
endmodule // becr_err_master
`default_nettype wire

/* File: becr_regs.v */
// Summary of operation
// R1: first bus error loads its full address only while the fault register is zero
// R2: any software write to the fault address register clears it to zero
// R3: a capture in the same cycle as a clearing write wins
// R4: error control bit 0 suppresses memory exceptions from bus errors, resets zero
// R5: interrupt control bit 0 selects direct vectors, resets to one
// R6: direct scheme gives each interrupt event its own vector
// R7: reserved bits read zero and ignore writes
//
// becr_regs.v: bus fault capture and control registers behind an AXI4-Lite slave
// assumes bus error strobe and address come from logic on the system clock
// assumes each register access is one aligned 32-bit word; other addresses answer with an error
// assumes interrupt events are levels on the system clock, so no synchroniser sits in front
// assumes one write and one read at most are in flight at a time
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "becr_defines.vh"

module becr_regs (
	input  wire                    sys_clk_i,          // system clock, 250 MHz
	input  wire                    sys_rst_i,          // async reset, active high
	input  wire                    s_axi_awvalid_i,    // write address valid
	output reg                     s_axi_awready_o,    // write address ready
	input  wire [`BECR_ADDR_W-1:0] s_axi_awaddr_i,     // write address
	input  wire                    s_axi_wvalid_i,     // write data valid
	output reg                     s_axi_wready_o,     // write data ready
	input  wire [31:0]             s_axi_wdata_i,      // write data
	input  wire [3:0]              s_axi_wstrb_i,      // write byte strobes
	output reg                     s_axi_bvalid_o,     // write response valid
	input  wire                    s_axi_bready_i,     // write response ready
	output reg  [1:0]              s_axi_bresp_o,      // write response
	input  wire                    s_axi_arvalid_i,    // read address valid
	output reg                     s_axi_arready_o,    // read address ready
	input  wire [`BECR_ADDR_W-1:0] s_axi_araddr_i,     // read address
	output reg                     s_axi_rvalid_o,     // read data valid
	input  wire                    s_axi_rready_i,     // read data ready
	output reg  [31:0]             s_axi_rdata_o,      // read data
	output reg  [1:0]              s_axi_rresp_o,      // read response
	input  wire                    bus_err_i,          // bus error pulse on master port
	input  wire [31:0]             bus_err_addr_i,     // address of the erroring access
	output reg                     exc_suppress_o,     // suppress memory exceptions
	output reg                     direct_vector_select_o, // direct vector scheme on
	input  wire [`BECR_IRQ_N-1:0]  irq_event_i,        // interrupt events
	output wire [`BECR_IRQ_N-1:0]  direct_irq_o,       // per-event vectors (flopped)
	output wire                    agg_irq_o           // aggregated vector (flopped)
);

	// ****************************************
	// write channel
	// ****************************************
	reg                     aw_held;
	reg  [`BECR_ADDR_W-1:0] aw_addr;
	reg                     w_held;
	reg  [31:0]             w_data;
	reg  [3:0]              w_strb;
	reg  [31:0]             fault_addr;
	reg                     suppress;
	reg                     direct_sel;

	// ****************************************
	// write decode
	// ****************************************
	// a write retires only once bvalid has cleared, so one response at most is pending
	wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
	wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
	wire wr_fire = aw_held & w_held & ~s_axi_bvalid_o;
	wire wr_fa   = wr_fire & (aw_addr == `BECR_OFF_FAULT_ADDR);
	wire wr_fc   = wr_fire & (aw_addr == `BECR_OFF_FAULT_CTRL);
	wire wr_vc   = wr_fire & (aw_addr == `BECR_OFF_VECTOR_CTRL);

	// address and data may arrive in either order; each is held until the write retires
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_held         <= 1'b0;
			aw_addr         <= {`BECR_ADDR_W{1'b0}};
			w_held          <= 1'b0;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `BECR_RESP_OKAY;
		end else begin
			// readies drop after a take so a held word cannot be overwritten
			s_axi_awready_o <= ~aw_held & ~aw_take & ~s_axi_bvalid_o;
			s_axi_wready_o  <= ~w_held & ~w_take & ~s_axi_bvalid_o;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				// unmapped writes answer with an error and change nothing
				s_axi_bresp_o  <= (wr_fa | wr_fc | wr_vc) ? `BECR_RESP_OKAY : `BECR_RESP_SLVERR;
			end else if (s_axi_bvalid_o & s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// ****************************************
	// register storage
	// ****************************************
	// capture only while empty so the first faulting address survives
	// an erroring address of zero leaves the register open to the next error
	wire capture = bus_err_i & (fault_addr == `BECR_FAULT_ADDR_RST); // R1

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fault_addr <= `BECR_FAULT_ADDR_RST;
		end else if (capture) begin
			fault_addr <= bus_err_addr_i; // R1 R3
		end else if (wr_fa) begin
			fault_addr <= `BECR_FAULT_ADDR_RST; // R2
		end
	end

	// ****************************************
	// control bits
	// ****************************************
	// only byte lane 0 holds a live bit; the other lanes are reserved
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			suppress   <= `BECR_FAULT_CTRL_RST; // R4
			direct_sel <= `BECR_VECTOR_CTRL_RST; // R5
		end else begin
			if (wr_fc & w_strb[0]) begin
				suppress <= w_data[`BECR_BIT_SUPPRESS]; // R4 R7
			end
			if (wr_vc & w_strb[0]) begin
				direct_sel <= w_data[`BECR_BIT_DIRECT]; // R5 R7
			end
		end
	end

	// ****************************************
	// control outputs
	// ****************************************
	// outputs trail the registers by one cycle so each leaves a flop
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exc_suppress_o         <= `BECR_FAULT_CTRL_RST;
			direct_vector_select_o <= `BECR_VECTOR_CTRL_RST;
		end else begin
			exc_suppress_o         <= suppress; // R4
			direct_vector_select_o <= direct_sel; // R5
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	reg [31:0] next_rdata;
	reg [1:0]  next_rresp;

	// unmapped reads return zero with an error response
	always @* begin
		next_rdata = 32'h0000_0000;
		next_rresp = `BECR_RESP_OKAY;
		case (s_axi_araddr_i)
			`BECR_OFF_FAULT_ADDR: begin
				next_rdata = fault_addr;
			end
			`BECR_OFF_FAULT_CTRL: begin
				next_rdata[`BECR_BIT_SUPPRESS] = suppress; // R7
			end
			`BECR_OFF_VECTOR_CTRL: begin
				next_rdata[`BECR_BIT_DIRECT] = direct_sel; // R7
			end
			default: begin
				next_rresp = `BECR_RESP_SLVERR;
			end
		endcase
	end

	// ****************************************
	// read response
	// ****************************************
	wire ar_take = s_axi_arvalid_i & s_axi_arready_o;

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= `BECR_RESP_OKAY;
		end else begin
			// arready idles low every other cycle; a waiting master is taken within two
			s_axi_arready_o <= ~s_axi_rvalid_o & ~ar_take & ~s_axi_arready_o;
			if (ar_take) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= next_rdata;
				s_axi_rresp_o  <= next_rresp;
			end else if (s_axi_rvalid_o & s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// ****************************************
	// interrupt vector steering
	// ****************************************
	// fed from the live register bit so vectors switch with direct_vector_select_o
	becr_vector_route u_route (
		.sys_clk_i    (sys_clk_i),
		.sys_rst_i    (sys_rst_i),
		.direct_i     (direct_sel),
		.event_i      (irq_event_i),
		.direct_irq_o (direct_irq_o),
		.agg_irq_o    (agg_irq_o)
	);

endmodule // becr_regs

`default_nettype wire

/* File: becr_regs_asserts.sv */
// becr_regs_asserts.sv: port checks for becr_regs
// assumes it is bound into becr_regs by the bench
`timescale 1ns/100ps
`default_nettype none
`include "becr_defines.vh"
module becr_regs_asserts (
	input wire logic                    sys_clk_i,              // clock
	input wire logic                    sys_rst_i,              // reset
	input wire logic                    s_axi_bvalid_o,         // write resp
	input wire logic                    s_axi_arvalid_i,        // read req
	input wire logic                    s_axi_arready_o,        // read ready
	input wire logic [`BECR_ADDR_W-1:0] s_axi_araddr_i,         // read addr
	input wire logic [31:0]             s_axi_rdata_o,          // read data
	input wire logic                    exc_suppress_o,         // suppress
	input wire logic                    direct_vector_select_o, // direct
	input wire logic [`BECR_IRQ_N-1:0]  irq_event_i,            // events
	input wire logic [`BECR_IRQ_N-1:0]  direct_irq_o,           // vectors
	input wire logic                    agg_irq_o               // shared
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// fault address is the only register allowed upper bits
	sequence ctl_read;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i != `BECR_OFF_FAULT_ADDR;
	endsequence
	reset_val_a: assert property ($past(sys_rst_i) |-> direct_vector_select_o && !exc_suppress_o)
		else $error("control reset values wrong");
	supp_change_a: assert property ($changed(exc_suppress_o) |-> $past(s_axi_bvalid_o))
		else $error("suppress changed without a write");
	dir_change_a: assert property ($changed(direct_vector_select_o) |-> $past(s_axi_bvalid_o))
		else $error("vector select changed without a write");
	direct_route_a: assert property (direct_irq_o == ($past(irq_event_i) & {`BECR_IRQ_N{direct_vector_select_o}}))
		else $error("direct vectors wrong");
	agg_route_a: assert property (agg_irq_o == ((|$past(irq_event_i)) && !direct_vector_select_o))
		else $error("aggregated vector wrong");
	rsvd_zero_a: assert property (ctl_read |=> s_axi_rdata_o[31:1] == 31'h0)
		else $error("reserved bits not zero");
endmodule // becr_regs_asserts
`default_nettype wire

/* File: becr_vector_route.v */
// becr_vector_route.v: steers interrupt events to direct vectors or to one aggregated vector
// assumes events are level requests on the system clock domain
`timescale 1ns/100ps
`default_nettype none

`include "becr_defines.vh"

module becr_vector_route (
	input  wire                    sys_clk_i,     // system clock
	input  wire                    sys_rst_i,     // async reset, active high
	input  wire                    direct_i,      // direct vector select
	input  wire [`BECR_IRQ_N-1:0]  event_i,       // interrupt events
	output reg  [`BECR_IRQ_N-1:0]  direct_irq_o,  // per-event vectors
	output reg                     agg_irq_o      // aggregated vector
);

	wire [`BECR_IRQ_N-1:0] next_direct_irq;

	// one gate per event; a single flop process keeps one driver on the vector
	genvar g;
	generate
		for (g = 0; g < `BECR_IRQ_N; g = g + 1) begin : g_route
			assign next_direct_irq[g] = direct_i & event_i[g]; // R6
		end
	endgenerate

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			direct_irq_o <= {`BECR_IRQ_N{1'b0}};
		end else begin
			direct_irq_o <= next_direct_irq; // R6
		end
	end

	// aggregated path only when the direct scheme is off
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			agg_irq_o <= 1'b0;
		end else begin
			agg_irq_o <= ~direct_i & (|event_i); // R6
		end
	end

endmodule // becr_vector_route

`default_nettype wire

/* File: bus_error_capture_regs_bench.sv */
// bus_error_capture_regs_bench.sv: self-checking bench for becr_regs
// assumes becr_err_master drives the bus error port
`timescale 1ns/100ps
`default_nettype none
`include "becr_defines.vh"
module bus_error_capture_regs_bench;
	typedef struct packed { logic [7:0] a; logic [31:0] d, q; logic [1:0] r, ctl; } becr_row_t;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, bus_err_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o, exc_suppress_o, direct_vector_select_o, agg_irq_o;
	logic [`BECR_ADDR_W-1:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
	logic [`BECR_IRQ_N-1:0] irq_event_i = 8'h0, direct_irq_o;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, bus_err_addr_i, got;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
	int miscompares = 0, num_checks = 0;
	becr_row_t rows [5] = '{
		'{`BECR_OFF_FAULT_CTRL, 32'hffff_ffff, 32'h1, `BECR_RESP_OKAY, 2'h3},
		'{`BECR_OFF_FAULT_CTRL, 32'hffff_fffe, 32'h0, `BECR_RESP_OKAY, 2'h1},
		'{`BECR_OFF_VECTOR_CTRL, 32'hffff_fffe, 32'h0, `BECR_RESP_OKAY, 2'h0},
		'{`BECR_OFF_VECTOR_CTRL, 32'h0000_0001, 32'h1, `BECR_RESP_OKAY, 2'h1},
		'{8'h20, 32'hffff_ffff, 32'h0, `BECR_RESP_SLVERR, 2'h1}};
	always #2 sys_clk_i = ~sys_clk_i;
	becr_regs dut (.*);
	becr_err_master cpu (.clk_i(sys_clk_i), .err_o(bus_err_i), .addr_o(bus_err_addr_i));
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		s_axi_awvalid_i <= 1'b1; s_axi_wvalid_i <= 1'b1; s_axi_bready_i <= 1'b1;
		s_axi_awaddr_i <= a; s_axi_wdata_i <= d;
		fork
			begin do @(posedge sys_clk_i); while (!s_axi_awready_o); s_axi_awvalid_i <= 1'b0; end
			begin do @(posedge sys_clk_i); while (!s_axi_wready_o); s_axi_wvalid_i <= 1'b0; end
		join
		do @(posedge sys_clk_i); while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0; resp = s_axi_bresp_o;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge sys_clk_i);
		s_axi_arvalid_i <= 1'b1; s_axi_araddr_i <= a; s_axi_rready_i <= 1'b1;
		do @(posedge sys_clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0; got = s_axi_rdata_o; resp = s_axi_rresp_o;
	endtask
	task close_out;
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d); chk({30'h0, resp}, {30'h0, rows[i].r});
			rd_reg(rows[i].a); chk(got, rows[i].q);
			chk({30'h0, resp}, {30'h0, rows[i].r}); chk({30'h0, exc_suppress_o, direct_vector_select_o}, {30'h0, rows[i].ctl});
		end
		// second error must not overwrite the first
		cpu.fire(32'hdead_0010); cpu.fire(32'h1234_5678);
		rd_reg(`BECR_OFF_FAULT_ADDR); chk(got, 32'hdead_0010);
		wr(`BECR_OFF_FAULT_ADDR, 32'hffff_ffff); rd_reg(`BECR_OFF_FAULT_ADDR); chk(got, 32'h0);
		fork
			wr(`BECR_OFF_FAULT_ADDR, 32'h5);
			begin @(posedge sys_clk_i); cpu.fire(32'h0bad_c0de); end
		join
		rd_reg(`BECR_OFF_FAULT_ADDR); chk(got, 32'h0bad_c0de);
		@(posedge sys_clk_i); irq_event_i <= 8'h5a; repeat (2) @(posedge sys_clk_i);
		chk({23'h0, direct_irq_o, agg_irq_o}, 32'hb4);
		wr(`BECR_OFF_VECTOR_CTRL, 32'h0);
		// vectors follow the new select one edge after the write lands
		@(posedge sys_clk_i); chk({23'h0, direct_irq_o, agg_irq_o}, 32'h1);
		irq_event_i <= 8'h0; sys_rst_i <= 1'b1; repeat (2) @(posedge sys_clk_i); sys_rst_i <= 1'b0;
		rd_reg(`BECR_OFF_FAULT_ADDR); chk(got, 32'h0);
		rd_reg(`BECR_OFF_FAULT_CTRL); chk(got, 32'h0);
		rd_reg(`BECR_OFF_VECTOR_CTRL); chk(got, 32'h1);
		close_out;
	end
	initial begin #20000; miscompares++; close_out; end
endmodule // bus_error_capture_regs_bench
bind becr_regs becr_regs_asserts mon (.*);
`default_nettype wire
